//--- verilog/pvc_pkg.sv
package pvc_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RANGE = 8'h04;
    localparam logic [7:0] ADDR_SCAL_LO = 8'h08;
    localparam logic [7:0] ADDR_SCAL_HI = 8'h0C;
    localparam logic [7:0] ADDR_GAIN = 8'h10;
    localparam logic [7:0] ADDR_OFFSET = 8'h14;
    localparam logic [7:0] ADDR_FILTER = 8'h18;
    localparam logic [7:0] ADDR_TARGET = 8'h1C;
    localparam logic [7:0] ADDR_PV = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_DP_LSB = 0;
    localparam int CTRL_HOLD_LSB = 2;
    localparam int STAT_OVR_BIT = 0;
    localparam int STAT_UND_BIT = 1;
    localparam int STAT_FLASH_BIT = 2;
    localparam int STAT_LIN_BIT = 3;

    // ****************************************
    // hold modes
    // ****************************************
    localparam logic [1:0] HOLD_NONE = 2'h0;
    localparam logic [1:0] HOLD_FIX = 2'h1;
    localparam logic [1:0] HOLD_MAX = 2'h2;
    localparam logic [1:0] HOLD_MIN = 2'h3;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [1:0] DP_RESET = 2'h0;
    localparam logic [1:0] DP_MAX = 2'h3;
    localparam logic [7:0] RANGE_RESET = 8'h54;      // 84, first linear range
    localparam logic [7:0] RANGE_LIN_FIRST = 8'h54;  // 84
    localparam logic [7:0] RANGE_LIN_LAST = 8'h5A;   // 90
    localparam logic [7:0] RANGE_RTD_A = 8'h35;      // 53
    localparam logic [7:0] RANGE_RTD_B = 8'h3F;      // 63
    localparam logic [7:0] RANGE_RTD_C = 8'h43;      // 67
    localparam logic signed [15:0] RTD_A_LO = -16'sd500;
    localparam logic signed [15:0] RTD_A_HI = 16'sd1000;
    localparam logic signed [15:0] RTD_B_LO = 16'sd0;
    localparam logic signed [15:0] RTD_B_HI = 16'sd2000;
    localparam logic signed [15:0] RTD_C_LO = 16'sd0;
    localparam logic signed [15:0] RTD_C_HI = 16'sd5000;
    localparam logic signed [15:0] SCAL_LO_RESET = 16'sd0;
    localparam logic signed [15:0] SCAL_HI_RESET = 16'sd1000;
    localparam logic signed [15:0] SET_MIN = -16'sd1999;
    localparam logic signed [15:0] SET_MAX = 16'sd9999;
    localparam logic [15:0] GAIN_MIN = 16'd1;
    localparam logic [15:0] GAIN_MAX = 16'd9999;
    localparam logic [15:0] GAIN_RESET = 16'd1000;
    localparam logic [15:0] GAIN_ONE = 16'd1000;      // ratio counts per 1.000
    localparam logic [15:0] FILT_RESET = 16'd0;       // tenths of a second
    localparam logic [15:0] FILT_MAX = 16'd1200;
    localparam logic [15:0] FS_DIV = 16'd10;          // 10 %FS margin
    localparam int ADC_W = 12;

    // ****************************************
    // timing
    // ****************************************
    localparam int PCLK_NS = 40;
    localparam int SAMPLE_NS = 500_000_000;
    localparam int SAMPLE_CYCLES = SAMPLE_NS / PCLK_NS;
    localparam logic [15:0] TS_TENTHS = 16'd5;       // sample period in tenths of a second
    localparam logic [5:0] DIV_STEPS = 6'd32;
endpackage : pvc_pkg

//--- verilog/pvc_fifo.sv
module pvc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("pvc_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end

    // storage has no reset, data only
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule : pvc_fifo

//--- verilog/pvc_top.sv
// The register addresses and the APB slave port were decided locally.
module pvc_top #(
    parameter int SAMPLE_CYCLES = pvc_pkg::SAMPLE_CYCLES,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic raw_valid,
    output logic raw_ready,
    input wire logic [15:0] raw_data,
    output logic signed [15:0] pv_value,
    output logic pv_valid,
    output logic pv_flash,
    output logic pv_over_range_alarm,
    output logic pv_under_range_alarm,
    output logic [1:0] decimal_point_select,
    output logic signed [15:0] target_value
);
    initial begin
        if (SAMPLE_CYCLES < 64) $error("pvc_top: SAMPLE_CYCLES too short for one processing pass");
    end

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LIM = 3'b001,
        S_LIMW = 3'b011,
        S_COMP = 3'b010,
        S_COMPW = 3'b110,
        S_FILT = 3'b111,
        S_FILTW = 3'b101,
        S_OUT = 3'b100
    } pvc_state_t;

    typedef struct packed {
        pvc_state_t st;
        logic [31:0] tick;
        logic [1:0] dp;
        logic [1:0] hold;
        logic [7:0] rng;
        logic signed [15:0] slo;
        logic signed [15:0] shi;
        logic signed [15:0] bias;
        logic signed [15:0] tgt;
        logic [15:0] gain;
        logic [15:0] flt;
        logic signed [31:0] x;
        logic signed [31:0] y;
        logic signed [31:0] filt;
        logic signed [31:0] lol;
        logic signed [31:0] hil;
        logic signed [15:0] pv;
        logic primed;
        logic ovr;
        logic und;
        logic vld;
        logic [31:0] num;
        logic [15:0] den;
        logic [16:0] rem;
        logic [5:0] cnt;
        logic neg;
        logic [31:0] rdata;
    } pvc_regs_t;

    pvc_regs_t q;
    pvc_regs_t d;
    logic smp_valid;
    logic smp_ready;
    logic [15:0] smp_data;

    // ****************************************
    // sample buffer
    // ****************************************
    // words wait here until the next tick; a slow tick stalls the source
    pvc_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(raw_valid),
        .in_ready(raw_ready),
        .in_data(raw_data),
        .out_valid(smp_valid),
        .out_ready(smp_ready),
        .out_data(smp_data)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    function automatic logic is_lin(input logic [7:0] r);
        is_lin = (r >= pvc_pkg::RANGE_LIN_FIRST) && (r <= pvc_pkg::RANGE_LIN_LAST);
    endfunction : is_lin

    function automatic logic rng_ok(input logic [7:0] r);
        rng_ok = is_lin(r) || r == pvc_pkg::RANGE_RTD_A || r == pvc_pkg::RANGE_RTD_B || r == pvc_pkg::RANGE_RTD_C;
    endfunction : rng_ok

    // range limits for sensor inputs; linear ranges use the scaling settings
    function automatic logic signed [15:0] eff_lo(input logic [7:0] r, input logic signed [15:0] s);
        unique case (r)
            pvc_pkg::RANGE_RTD_A: eff_lo = pvc_pkg::RTD_A_LO;
            pvc_pkg::RANGE_RTD_B: eff_lo = pvc_pkg::RTD_B_LO;
            pvc_pkg::RANGE_RTD_C: eff_lo = pvc_pkg::RTD_C_LO;
            default: eff_lo = s;
        endcase
    endfunction : eff_lo

    function automatic logic signed [15:0] eff_hi(input logic [7:0] r, input logic signed [15:0] s);
        unique case (r)
            pvc_pkg::RANGE_RTD_A: eff_hi = pvc_pkg::RTD_A_HI;
            pvc_pkg::RANGE_RTD_B: eff_hi = pvc_pkg::RTD_B_HI;
            pvc_pkg::RANGE_RTD_C: eff_hi = pvc_pkg::RTD_C_HI;
            default: eff_hi = s;
        endcase
    endfunction : eff_hi

    function automatic logic set_ok(input logic [31:0] w);
        set_ok = ($signed(w) >= 32'(pvc_pkg::SET_MIN)) && ($signed(w) <= 32'(pvc_pkg::SET_MAX));
    endfunction : set_ok

    logic signed [15:0] lo_e;
    logic signed [15:0] hi_e;
    logic acc;
    logic wr_err;
    logic rd_map;
    logic [31:0] rd_val;
    logic [16:0] rsh;
    logic signed [31:0] span;
    logic signed [31:0] cand;

    assign lo_e = eff_lo(q.rng, q.slo);
    assign hi_e = eff_hi(q.rng, q.shi);
    assign acc = psel && penable;
    assign span = 32'(hi_e) - 32'(lo_e);

    // ****************************************
    // apb decode
    // ****************************************
    // read mux, sampled in the setup cycle so prdata is a flop
    always_comb begin
        rd_map = 1'b1;
        rd_val = '0;
        unique case (paddr)
            pvc_pkg::ADDR_CTRL: begin
                rd_val[pvc_pkg::CTRL_DP_LSB +: 2] = q.dp;
                rd_val[pvc_pkg::CTRL_HOLD_LSB +: 2] = q.hold;
            end
            pvc_pkg::ADDR_RANGE: rd_val[7:0] = q.rng;
            pvc_pkg::ADDR_SCAL_LO: rd_val = 32'(lo_e);
            pvc_pkg::ADDR_SCAL_HI: rd_val = 32'(hi_e);
            pvc_pkg::ADDR_GAIN: rd_val[15:0] = q.gain;
            pvc_pkg::ADDR_OFFSET: rd_val = 32'(q.bias);
            pvc_pkg::ADDR_FILTER: rd_val[15:0] = q.flt;
            pvc_pkg::ADDR_TARGET: rd_val = 32'(q.tgt);
            pvc_pkg::ADDR_PV: rd_val = 32'(q.pv);
            pvc_pkg::ADDR_STATUS: begin
                rd_val[pvc_pkg::STAT_OVR_BIT] = q.ovr;
                rd_val[pvc_pkg::STAT_UND_BIT] = q.und;
                rd_val[pvc_pkg::STAT_FLASH_BIT] = (q.hold != pvc_pkg::HOLD_NONE);
                rd_val[pvc_pkg::STAT_LIN_BIT] = is_lin(q.rng);
            end
            default: rd_map = 1'b0;
        endcase
    end

    // write checks: out-of-range values are refused with pslverr, nothing stored
    always_comb begin
        wr_err = 1'b0;
        unique case (paddr)
            pvc_pkg::ADDR_CTRL: wr_err = 1'b0;
            pvc_pkg::ADDR_RANGE: wr_err = !rng_ok(pwdata[7:0]) || (pwdata[31:8] != '0);
            pvc_pkg::ADDR_SCAL_LO, pvc_pkg::ADDR_SCAL_HI: wr_err = !is_lin(q.rng) || !set_ok(pwdata);
            pvc_pkg::ADDR_GAIN: wr_err = (pwdata < 32'(pvc_pkg::GAIN_MIN)) || (pwdata > 32'(pvc_pkg::GAIN_MAX));
            pvc_pkg::ADDR_OFFSET, pvc_pkg::ADDR_TARGET: wr_err = !set_ok(pwdata);
            pvc_pkg::ADDR_FILTER: wr_err = pwdata > 32'(pvc_pkg::FILT_MAX);
            default: wr_err = 1'b1;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = acc && (pwrite ? wr_err : !rd_map);
    assign prdata = q.rdata;
    assign smp_ready = (q.st == S_IDLE) && (q.tick == '0);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.vld = 1'b0;
        rsh = '0;
        cand = '0;
        if (psel && !penable && !pwrite) begin
            d.rdata = rd_map ? rd_val : '0;
        end
        // register writes take effect in the access cycle
        if (acc && pwrite && !wr_err) begin
            unique case (paddr)
                pvc_pkg::ADDR_CTRL: begin
                    // dependent settings hold raw counts, so the point moves with them
                    d.dp = pwdata[pvc_pkg::CTRL_DP_LSB +: 2];
                    d.hold = pwdata[pvc_pkg::CTRL_HOLD_LSB +: 2];
                end
                pvc_pkg::ADDR_RANGE: begin
                    d.rng = pwdata[7:0];
                    if (is_lin(pwdata[7:0])) begin
                        d.slo = pvc_pkg::SCAL_LO_RESET;
                        d.shi = pvc_pkg::SCAL_HI_RESET;
                    end
                end
                pvc_pkg::ADDR_SCAL_LO: d.slo = pwdata[15:0];
                pvc_pkg::ADDR_SCAL_HI: d.shi = pwdata[15:0];
                pvc_pkg::ADDR_GAIN: d.gain = pwdata[15:0];
                pvc_pkg::ADDR_OFFSET: d.bias = pwdata[15:0];
                pvc_pkg::ADDR_FILTER: d.flt = pwdata[15:0];
                pvc_pkg::ADDR_TARGET: d.tgt = pwdata[15:0];
                default: d.tgt = q.tgt;
            endcase
        end
        // sampling tick: the counter runs whether or not a word is waiting
        d.tick = (q.tick == '0) ? 32'(SAMPLE_CYCLES - 1) : q.tick - 32'd1;
        // shared restoring divider, one quotient bit per cycle
        if (q.cnt != '0) begin
            rsh = {q.rem[15:0], q.num[31]};
            d.num = {q.num[30:0], 1'b0};
            d.rem = rsh;
            if (rsh >= {1'b0, q.den}) begin
                d.rem = rsh - {1'b0, q.den};
                d.num[0] = 1'b1;
            end
            d.cnt = q.cnt - 6'd1;
        end
        unique case (q.st)
            S_IDLE: begin
                if (smp_ready && smp_valid) begin
                    // linear inputs scale a full-span code onto lo..hi
                    if (is_lin(q.rng)) begin
                        d.x = 32'(lo_e) + ((span * $signed({1'b0, smp_data[pvc_pkg::ADC_W-1:0]})) >>>
                            pvc_pkg::ADC_W);
                    end else begin
                        d.x = 32'($signed(smp_data));
                    end
                    d.st = S_LIM;
                end
            end
            S_LIM: begin
                d.num = mag(span);
                d.den = pvc_pkg::FS_DIV;
                d.rem = '0;
                d.cnt = pvc_pkg::DIV_STEPS;
                d.st = S_LIMW;
            end
            S_LIMW: begin
                if (q.cnt == '0) begin
                    d.lol = 32'(lo_e) - 32'(q.num);
                    d.hil = 32'(hi_e) + 32'(q.num);
                    d.ovr = q.x > d.hil;
                    d.und = q.x < d.lol;
                    d.st = S_COMP;
                end
            end
            S_COMP: begin
                d.num = mag(q.x * 32'($signed({1'b0, q.gain})));
                d.neg = q.x[31];
                d.den = pvc_pkg::GAIN_ONE;
                d.rem = '0;
                d.cnt = pvc_pkg::DIV_STEPS;
                d.st = S_COMPW;
            end
            S_COMPW: begin
                if (q.cnt == '0) begin
                    d.y = (q.neg ? 32'(-$signed(q.num)) : $signed(q.num)) + 32'(q.bias);
                    d.st = S_FILT;
                end
            end
            S_FILT: begin
                // first sample seeds the filter so it does not ramp up from zero
                if (q.flt == '0 || !q.primed) begin
                    d.filt = q.y;
                    d.primed = 1'b1;
                    d.st = S_OUT;
                end else begin
                    // divisor T/Ts+1 in tenths: (T+Ts)/Ts, so scale the step by Ts
                    d.num = mag((q.y - q.filt) * 32'($signed({1'b0, pvc_pkg::TS_TENTHS})));
                    d.neg = (q.y < q.filt);
                    d.den = q.flt + pvc_pkg::TS_TENTHS;
                    d.rem = '0;
                    d.cnt = pvc_pkg::DIV_STEPS;
                    d.st = S_FILTW;
                end
            end
            S_FILTW: begin
                if (q.cnt == '0) begin
                    d.filt = q.neg ? q.filt - $signed(q.num) : q.filt + $signed(q.num);
                    d.st = S_OUT;
                end
            end
            S_OUT: begin
                // hold, then clamp; the filter keeps tracking underneath a hold
                unique case (q.hold)
                    pvc_pkg::HOLD_FIX: cand = 32'(q.pv);
                    pvc_pkg::HOLD_MAX: cand = (q.filt > 32'(q.pv)) ? q.filt : 32'(q.pv);
                    pvc_pkg::HOLD_MIN: cand = (q.filt < 32'(q.pv)) ? q.filt : 32'(q.pv);
                    default: cand = q.filt;
                endcase
                if (cand > q.hil) cand = q.hil;
                if (cand < q.lol) cand = q.lol;
                d.pv = cand[15:0];
                d.vld = 1'b1;
                d.st = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{
                st: S_IDLE, tick: 32'h0000_0000, dp: pvc_pkg::DP_RESET, hold: pvc_pkg::HOLD_NONE,
                rng: pvc_pkg::RANGE_RESET, slo: pvc_pkg::SCAL_LO_RESET, shi: pvc_pkg::SCAL_HI_RESET,
                bias: 16'sh0000, tgt: 16'sh0000, gain: pvc_pkg::GAIN_RESET, flt: pvc_pkg::FILT_RESET,
                x: 32'sh0000_0000, y: 32'sh0000_0000, filt: 32'sh0000_0000, lol: 32'sh0000_0000,
                hil: 32'sh0000_0000, pv: 16'sh0000, primed: 1'b0, ovr: 1'b0, und: 1'b0, vld: 1'b0,
                num: 32'h0000_0000, den: 16'h0001, rem: 17'h0_0000, cnt: 6'h00, neg: 1'b0,
                rdata: 32'h0000_0000
            };
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pv_value = q.pv;
    assign pv_valid = q.vld;
    assign pv_flash = (q.hold != pvc_pkg::HOLD_NONE);
    assign pv_over_range_alarm = q.ovr;
    assign pv_under_range_alarm = q.und;
    assign decimal_point_select = q.dp;
    assign target_value = q.tgt;
endmodule : pvc_top

//--- tb/pvc_props.sv
module pvc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic signed [15:0] pv_value,
    input wire logic pv_valid,
    input wire logic pv_flash,
    input wire logic [1:0] decimal_point_select,
    input wire logic signed [15:0] target_value
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic att;
    logic [1:0] hold_q;
    logic armed_q;
    logic signed [15:0] last_q;
    // ****************************************
    // shadow of hold mode and last value
    // ****************************************
    assign att = psel && penable && pwrite;
    assign wr = att && !pslverr;
    // armed only after one value under the current mode, so a mode change never trips a check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 2'h0;
            armed_q <= 1'b0;
            last_q <= 16'sh0;
        end else begin
            if (wr && paddr == pvc_pkg::ADDR_CTRL) begin
                hold_q <= pwdata[3:2];
                armed_q <= 1'b0;
            end else if (pv_valid) begin
                armed_q <= 1'b1;
            end
            if (pv_valid) begin
                last_q <= pv_value;
            end
        end
    end
    sequence s_ctrl_wr;
        wr && paddr == pvc_pkg::ADDR_CTRL;
    endsequence
    sequence s_held(logic [1:0] m);
        pv_valid && armed_q && hold_q == m;
    endsequence
    a_dp_follow: assert property (s_ctrl_wr |=> decimal_point_select == $past(pwdata[1:0]))
        else $error("dp code");
    a_flash_hold: assert property (s_ctrl_wr |=> pv_flash == ($past(pwdata[3:2]) != 2'h0)) else $error("flash");
    a_target_raw: assert property (wr && paddr == pvc_pkg::ADDR_TARGET |=> target_value == $past(pwdata[15:0]))
        else $error("target");
    a_hold_fix: assert property (s_held(pvc_pkg::HOLD_FIX) |-> pv_value == last_q) else $error("fix");
    a_hold_max: assert property (s_held(pvc_pkg::HOLD_MAX) |-> pv_value >= last_q) else $error("max");
    a_hold_min: assert property (s_held(pvc_pkg::HOLD_MIN) |-> pv_value <= last_q) else $error("min");
    a_pv_pulse: assert property (pv_valid |=> !pv_valid [*8]) else $error("pv pulse");
    a_bias_limit: assert property (att && paddr == pvc_pkg::ADDR_OFFSET && $signed(pwdata) > 32'sd9999
        |-> pslverr) else $error("bias");
    a_filt_limit: assert property (att && paddr == pvc_pkg::ADDR_FILTER && pwdata > 32'd1200 |-> pslverr)
        else $error("filter");
endmodule : pvc_props

bind pvc_top pvc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .pv_value, .pv_valid, .pv_flash, .decimal_point_select, .target_value);

//--- tb/pvc_sensor.sv
module pvc_sensor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic raw_ready,
    output logic raw_valid,
    output logic [15:0] raw_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] q[$];
    // offer queued words; an idle bus shows a toggling pattern, the last word and its inverse in turn
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_valid <= 1'b0;
            raw_data <= 16'h0;
        end else if (!raw_valid || raw_ready) begin
            if (q.size() > 0 && !(slow && $urandom_range(1, 0) == 1)) begin
                raw_valid <= 1'b1;
                raw_data <= q.pop_front();
            end else begin
                raw_valid <= 1'b0;
                raw_data <= ~raw_data;
            end
        end
    end
endmodule : pvc_sensor

//--- tb/pvc_top_tb.sv
module pvc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, raw_valid, raw_ready, pv_valid, pv_flash;
    logic pv_over_range_alarm, pv_under_range_alarm;
    logic [15:0] raw_data;
    logic signed [15:0] pv_value, target_value;
    logic [1:0] decimal_point_select;
    int miscompares = 0, checks = 0, c, g, o;
    pvc_top #(.SAMPLE_CYCLES(200)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .raw_valid, .raw_ready, .raw_data, .pv_value, .pv_valid, .pv_flash,
        .pv_over_range_alarm, .pv_under_range_alarm, .decimal_point_select, .target_value);
    pvc_sensor u_sen (.pclk, .presetn, .slow, .raw_ready, .raw_valid, .raw_data);
    initial forever #20 pclk = ~pclk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        if (n >= 50) test_done();
        rd = prdata;
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input int d, input logic e = 1'b0);
        apb(1'b1, a, d, e);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input int d, input logic e = 1'b0);
        apb(1'b0, a, 32'h0, e);
        chk("prdata", d, rd);
    endtask : rdc
    // one processed value; ticks come every 200 cycles and processing runs inside one
    task automatic wt(input int pv, input logic ov = 1'b0, input logic un = 1'b0);
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pv_valid !== 1'b1 && n < 600);
        if (n >= 600) miscompares++;
        if (n >= 600) test_done();
        chk("pv_value", {16'h0, 16'(pv)}, {16'h0, pv_value});
        chk("alarms", {30'h0, ov, un}, {30'h0, pv_over_range_alarm, pv_under_range_alarm});
    endtask : wt
    task automatic samp(input logic [15:0] raw, input int pv, input logic ov = 1'b0, input logic un = 1'b0);
        u_sen.q.push_back(raw);
        wt(pv, ov, un);
    endtask : samp
    function automatic int lin(int code, int lo, int hi);
        return lo + (((hi - lo) * code) >>> 12);
    endfunction : lin
    function automatic int pv_exp(int x, int gn, int of, int lo, int hi);
        int v, m;
        m = (hi - lo) / 10;
        v = x * gn / 1000 + of;
        v = v > hi + m ? hi + m : v;
        return v < lo - m ? lo - m : v;
    endfunction : pv_exp
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(88));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdc(8'(4 * i), i == 1 ? 84 : (i == 3 || i == 4) ? 1000 : 0);
        rdc(pvc_pkg::ADDR_STATUS, 32'h8);
        rdc(8'h40, 0, 1'b1);
        wr(pvc_pkg::ADDR_PV, 0, 1'b1);
        wr(pvc_pkg::ADDR_FILTER, 1201, 1'b1);
        wr(pvc_pkg::ADDR_GAIN, 0, 1'b1);
        wr(pvc_pkg::ADDR_OFFSET, 10000, 1'b1);
        wr(pvc_pkg::ADDR_SCAL_HI, 10000, 1'b1);
        wr(pvc_pkg::ADDR_SCAL_LO, -1999);
        rdc(pvc_pkg::ADDR_SCAL_LO, -1999);
        wr(pvc_pkg::ADDR_SCAL_LO, 0);
        wr(pvc_pkg::ADDR_TARGET, 1234);
        for (int m = 0; m < 16; m++) begin
            wr(pvc_pkg::ADDR_CTRL, m);
            chk("dp", m & 3, {30'h0, decimal_point_select});
            chk("target", 1234, {16'h0, target_value});
            chk("flash", m > 3, {31'h0, pv_flash});
        end
        wr(pvc_pkg::ADDR_CTRL, 0);
        $display("test registers finished");
        for (int i = 0; i < 12; i++) begin
            c = i == 0 ? 4095 : i == 1 ? 0 : $urandom_range(4095, 0);
            g = i == 0 ? 9999 : $urandom_range(9999, 1);
            o = i == 0 ? 9999 : i == 1 ? -1999 : $urandom_range(11998, 0) - 1999;
            wr(pvc_pkg::ADDR_GAIN, g);
            wr(pvc_pkg::ADDR_OFFSET, o);
            samp(c, pv_exp(lin(c, 0, 1000), g, o, 0, 1000));
        end
        wr(pvc_pkg::ADDR_GAIN, 1000);
        wr(pvc_pkg::ADDR_OFFSET, 0);
        $display("test compensation finished");
        samp(2048, 500);
        wr(pvc_pkg::ADDR_FILTER, 10);
        samp(2048, 500);
        samp(0, 500 - 500 * 5 / 15);
        wr(pvc_pkg::ADDR_FILTER, 0);
        samp(0, 0);
        samp(2048, 500);
        $display("test filter finished");
        wr(pvc_pkg::ADDR_CTRL, pvc_pkg::HOLD_MAX << 2);
        samp(1024, 500);
        samp(4095, 999);
        wr(pvc_pkg::ADDR_CTRL, pvc_pkg::HOLD_MIN << 2);
        samp(4095, 999);
        samp(1024, 250);
        wr(pvc_pkg::ADDR_CTRL, pvc_pkg::HOLD_FIX << 2);
        samp(2048, 250);
        samp(0, 250);
        wr(pvc_pkg::ADDR_CTRL, 0);
        $display("test hold finished");
        wr(pvc_pkg::ADDR_SCAL_HI, 2000);
        samp(4095, lin(4095, 0, 2000));
        wr(pvc_pkg::ADDR_RANGE, 54, 1'b1);
        wr(pvc_pkg::ADDR_RANGE, 53);
        rdc(pvc_pkg::ADDR_SCAL_HI, 1000);
        wr(pvc_pkg::ADDR_SCAL_LO, 0, 1'b1);
        samp(1200, 1150, 1'b1);
        samp(-700, -650, 1'b0, 1'b1);
        samp(500, 500);
        wr(pvc_pkg::ADDR_RANGE, 84);
        rdc(pvc_pkg::ADDR_SCAL_HI, 1000);
        $display("test ranges finished");
        slow <= 1'b1;
        repeat (20) u_sen.q.push_back(16'h0800);
        repeat (100) @(posedge pclk);
        chk("raw_ready", 32'h0, {31'h0, raw_ready});
        repeat (20) wt(500);
        $display("test buffer finished");
        test_done();
    end
endmodule : pvc_top_tb
